// file: hw/arc_pkg.sv
package arc_pkg;

    // ==========================================
    // register pages and addresses
    localparam logic [1:0]  PAGE_RESULT      = 2'h0;
    localparam logic [1:0]  PAGE_CONFIG      = 2'h2;
    localparam logic [5:0]  ADDR_SINE_RAW    = 6'h10;
    localparam logic [5:0]  ADDR_COSINE_RAW  = 6'h11;
    localparam logic [5:0]  ADDR_VECTOR_MAG  = 6'h18;
    localparam logic [5:0]  ADDR_DIE_TEMP    = 6'h20;
    localparam logic [5:0]  ADDR_GEN_CTRL    = 6'h10;

    // ==========================================
    // reset and load values
    localparam logic [15:0] RESULT_RESET     = 16'h0000;
    localparam logic [15:0] SINCOS_START     = 16'h2000;
    localparam logic [15:0] TEMP_START       = 16'hFFF0;
    localparam logic [15:0] GEN_CTRL_RESET   = 16'h1230;

    // ==========================================
    // general control and result field positions
    localparam int          POS_STORAGE7     = 15;
    localparam int          POS_SYNC_HI      = 14;
    localparam int          POS_SYNC_LO      = 13;
    localparam int          POS_FILTER       = 12;
    localparam int          POS_STORAGE6     = 11;
    localparam int          POS_H8_SOURCE    = 10;
    localparam int          POS_STORAGE5     = 8;
    localparam int          POS_STORAGE3     = 6;
    localparam int          POS_STORAGE2     = 3;
    localparam int          POS_STORAGE0     = 1;
    localparam int          POS_MODE         = 0;
    localparam int          POS_FLAG         = 0;
    localparam int          SINCOS_LSB       = 2;
    localparam int          MAG_LSB          = 1;
    localparam int          TEMP_LSB         = 4;

    // ==========================================
    // conversion sequencer states
    typedef enum logic [1:0] {
        ARC_IDLE = 2'b01,
        ARC_RUN  = 2'b10
    } arc_seq_e;

    // ==========================================
    // carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  page;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } arc_req_s;

    typedef struct packed {
        logic        valid;
        logic [13:0] sine;
        logic [13:0] cosine;
        logic [14:0] magnitude;
        logic [11:0] temperature;
    } arc_meas_s;

    typedef struct packed {
        logic [1:0]  start_sync_select;
        logic        angle_filter_enable;
        logic        eighth_harmonic_source;
        logic        conversion_mode_select;
        logic [7:0]  user_storage;
    } arc_cfg_s;

endpackage

// file: hw/arc_regs.sv
`timescale 1ns/100ps
module arc_regs (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset,
    // host register port
    input  wire arc_pkg::arc_req_s req,
    output logic [15:0]            rd_data,
    output logic                   rd_valid,
    // conversion front end
    input  wire logic              convert_start,
    input  wire arc_pkg::arc_meas_s meas,
    output logic                   seq_start,
    output logic                   seq_running,
    // configuration out
    output arc_pkg::arc_cfg_s      cfg,
    output logic [4:0]             ecc_check
);

    // ==========================================
    // storage
    logic [15:0]       sine_raw;
    logic [15:0]       cosine_raw;
    logic [15:0]       vector_magnitude;
    logic [15:0]       die_temperature;
    logic [15:0]       general_control;
    arc_pkg::arc_seq_e state;
    logic              begin_seq;
    logic              one_shot;
    logic              rd_result;
    logic              rd_sine;
    logic              rd_cosine;
    logic              rd_mag;
    logic              wr_gen;
    logic              fresh;
    logic [15:0]       next_rd_data;
    logic [7:0]        storage_bits;

    assign one_shot  = general_control[arc_pkg::POS_MODE];
    assign rd_result = req.rd && req.page == arc_pkg::PAGE_RESULT;
    assign rd_sine   = rd_result && req.addr == arc_pkg::ADDR_SINE_RAW;
    assign rd_cosine = rd_result && req.addr == arc_pkg::ADDR_COSINE_RAW;
    assign rd_mag    = rd_result && req.addr == arc_pkg::ADDR_VECTOR_MAG;
    // only the general control register accepts writes
    assign wr_gen    = req.wr && req.page == arc_pkg::PAGE_CONFIG
                       && req.addr == arc_pkg::ADDR_GEN_CTRL;
    assign fresh     = meas.valid && state == arc_pkg::ARC_RUN && !one_shot;

    // ==========================================
    // conversion sequencer
    always_comb begin
        unique case (state)
            arc_pkg::ARC_IDLE: begin_seq = convert_start;
            arc_pkg::ARC_RUN:  begin_seq = meas.valid && !one_shot;
            default:           begin_seq = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= arc_pkg::ARC_IDLE;
        end else begin
            unique case (state)
                arc_pkg::ARC_IDLE: begin
                    if (convert_start) begin
                        state <= arc_pkg::ARC_RUN;
                    end
                end
                arc_pkg::ARC_RUN: begin
                    // one-shot halts after its sequence completes
                    if (meas.valid && one_shot) begin
                        state <= arc_pkg::ARC_IDLE;
                    end
                end
                default: state <= arc_pkg::ARC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            seq_start   <= 1'b0;
            seq_running <= 1'b0;
        end else begin
            seq_start   <= begin_seq;
            seq_running <= state == arc_pkg::ARC_RUN || begin_seq;
        end
    end

    // ==========================================
    // sine and cosine results
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sine_raw   <= arc_pkg::RESULT_RESET;
            cosine_raw <= arc_pkg::RESULT_RESET;
        end else begin
            // completed result wins over the continuous restart load
            if (meas.valid && state == arc_pkg::ARC_RUN) begin
                sine_raw[15:arc_pkg::SINCOS_LSB]   <= meas.sine;
                cosine_raw[15:arc_pkg::SINCOS_LSB] <= meas.cosine;
                sine_raw[1]                        <= 1'b0;
                cosine_raw[1]                      <= 1'b0;
            end else if (begin_seq) begin
                sine_raw   <= arc_pkg::SINCOS_START;
                cosine_raw <= arc_pkg::SINCOS_START;
            end
            // new-data flags: arrival wins over read clear
            if (one_shot) begin
                sine_raw[arc_pkg::POS_FLAG]   <= 1'b0;
                cosine_raw[arc_pkg::POS_FLAG] <= 1'b0;
            end else begin
                if (fresh) begin
                    sine_raw[arc_pkg::POS_FLAG]   <= 1'b1;
                    cosine_raw[arc_pkg::POS_FLAG] <= 1'b1;
                end else begin
                    if (rd_sine) begin
                        sine_raw[arc_pkg::POS_FLAG] <= 1'b0;
                    end
                    if (rd_cosine) begin
                        cosine_raw[arc_pkg::POS_FLAG] <= 1'b0;
                    end
                end
            end
        end
    end

    // ==========================================
    // magnitude and temperature
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            vector_magnitude <= arc_pkg::RESULT_RESET;
        end else begin
            if (meas.valid && state == arc_pkg::ARC_RUN) begin
                vector_magnitude[15:arc_pkg::MAG_LSB] <= meas.magnitude;
            end
            if (one_shot) begin
                vector_magnitude[arc_pkg::POS_FLAG] <= 1'b0;
            end else if (fresh) begin
                vector_magnitude[arc_pkg::POS_FLAG] <= 1'b1;
            end else if (rd_mag) begin
                vector_magnitude[arc_pkg::POS_FLAG] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            die_temperature <= arc_pkg::RESULT_RESET;
        end else if (meas.valid && state == arc_pkg::ARC_RUN) begin
            die_temperature <= {meas.temperature, 4'h0};
        end else if (begin_seq) begin
            die_temperature <= arc_pkg::TEMP_START;
        end
    end

    // ==========================================
    // general control
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            general_control <= arc_pkg::GEN_CTRL_RESET;
        end else if (wr_gen) begin
            // all bits stored as written; host keeps the fixed bits
            general_control <= req.wdata;
        end
    end

    assign storage_bits = {general_control[arc_pkg::POS_STORAGE7],
                           general_control[arc_pkg::POS_STORAGE6],
                           general_control[arc_pkg::POS_STORAGE5:arc_pkg::POS_STORAGE3],
                           general_control[arc_pkg::POS_STORAGE2:arc_pkg::POS_STORAGE0]};

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg       <= '0;
            ecc_check <= 5'h00;
        end else begin
            cfg.start_sync_select      <= general_control[arc_pkg::POS_SYNC_HI:
                                                          arc_pkg::POS_SYNC_LO];
            cfg.angle_filter_enable    <= general_control[arc_pkg::POS_FILTER];
            cfg.eighth_harmonic_source <= general_control[arc_pkg::POS_H8_SOURCE];
            cfg.conversion_mode_select <= one_shot;
            cfg.user_storage           <= storage_bits;
            // check bits over the whole word, storage bits included
            ecc_check[0] <= ^(general_control & 16'h5555);
            ecc_check[1] <= ^(general_control & 16'h6666);
            ecc_check[2] <= ^(general_control & 16'h7878);
            ecc_check[3] <= ^(general_control & 16'h7F80);
            ecc_check[4] <= ^general_control;
        end
    end

    // ==========================================
    // read path
    always_comb begin
        next_rd_data = 16'h0000;
        if (req.page == arc_pkg::PAGE_RESULT) begin
            unique case (req.addr)
                arc_pkg::ADDR_SINE_RAW:   next_rd_data = sine_raw;
                arc_pkg::ADDR_COSINE_RAW: next_rd_data = cosine_raw;
                arc_pkg::ADDR_VECTOR_MAG: next_rd_data = vector_magnitude;
                arc_pkg::ADDR_DIE_TEMP:   next_rd_data = die_temperature;
                default:                  next_rd_data = 16'h0000;
            endcase
        end else if (req.page == arc_pkg::PAGE_CONFIG && req.addr == arc_pkg::ADDR_GEN_CTRL) begin
            next_rd_data = general_control;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= next_rd_data;
            end
        end
    end

endmodule

// file: sim/arc_host_model.sv
`timescale 1ns/100ps
module arc_host_model (
    // register port
    input  wire logic         mclk,
    input  wire logic [15:0]  rd_data,
    input  wire logic         rd_valid,
    output arc_pkg::arc_req_s req
);
    initial req = '0;
    // ==========================================
    // host side temperature conversion to degrees
    function automatic real to_celsius(input logic [15:0] w);
        return (real'(w[15:4]) - 1168.0) / 15.66;
    endfunction
    // ==========================================
    // one register access, pulse then wait
    task automatic access(input logic w, input logic [1:0] p, input logic [5:0] a,
                          input logic [15:0] d, output logic [15:0] q, output bit ok);
        @(posedge mclk);
        #1 req = '{rd: !w, wr: w, page: p, addr: a, wdata: d};
        @(posedge mclk);
        #1 req = '{rd: 1'b0, wr: 1'b0, page: ~p, addr: ~a, wdata: ~d};
        ok = w;
        q = 16'h0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid === 1'b1) begin
                ok = 1;
                q = rd_data;
            end else begin
                @(posedge mclk);
                #1;
            end
        end
    endtask
endmodule

// file: sim/arc_regs_monitor.sv
`timescale 1ns/100ps
module arc_regs_monitor (
    // watched ports
    input wire logic               mclk,
    input wire logic               reset,
    input wire arc_pkg::arc_req_s  req,
    input wire logic [15:0]        rd_data,
    input wire logic               rd_valid,
    input wire logic               convert_start,
    input wire arc_pkg::arc_meas_s meas,
    input wire logic               seq_start,
    input wire logic               seq_running,
    input wire arc_pkg::arc_cfg_s  cfg,
    input wire logic [4:0]         ecc_check
);
    // ==========================================
    // helpers
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [15:0] last_w;
    wire         wr_ctrl = req.wr && req.page == arc_pkg::PAGE_CONFIG
                           && req.addr == arc_pkg::ADDR_GEN_CTRL;
    always_ff @(posedge mclk) begin
        if (wr_ctrl) begin
            last_w <= req.wdata;
        end
    end
    function automatic logic [12:0] f_cfg(input logic [15:0] w);
        return {w[14:13], w[12], w[10], w[0], w[15], w[11], w[8:6], w[3:1]};
    endfunction
    sequence s_rd(a);
        req.rd && req.page == arc_pkg::PAGE_RESULT && req.addr == a;
    endsequence
    sequence s_rd_quiet(a);
        s_rd(a) ##0 !meas.valid;
    endsequence
    // ==========================================
    // assertions
    chk_rd_valid_timing: assert property (1 |=> rd_valid == $past(req.rd))
        else $error("rd_valid not one cycle after read");
    chk_temp_low_nibble: assert property (
        s_rd(arc_pkg::ADDR_DIE_TEMP) |=> rd_data[3:0] == 4'h0)
        else $error("temperature low bits not zero");
    chk_sincos_bit_one: assert property (
        (s_rd(arc_pkg::ADDR_SINE_RAW) or s_rd(arc_pkg::ADDR_COSINE_RAW)) |=> !rd_data[1])
        else $error("sine or cosine bit 1 set");
    chk_read_clears_flag: assert property (
        s_rd_quiet(arc_pkg::ADDR_VECTOR_MAG) ##1 !meas.valid ##1 s_rd(arc_pkg::ADDR_VECTOR_MAG)
        |=> !rd_data[0])
        else $error("flag not cleared by read");
    chk_oneshot_flag_low: assert property (
        (s_rd(arc_pkg::ADDR_SINE_RAW) or s_rd(arc_pkg::ADDR_VECTOR_MAG))
        ##0 (cfg.conversion_mode_select && $past(cfg.conversion_mode_select))
        |=> !rd_data[0])
        else $error("flag high in one-shot");
    chk_ctrl_reset_val: assert property ($fell(reset) |-> ##[1:3] cfg == 13'h0400)
        else $error("control reset value wrong");
    chk_cfg_follows_wr: assert property (wr_ctrl |-> ##[2:3] cfg == f_cfg(last_w))
        else $error("cfg does not follow write");
    chk_start_pulse: assert property ($rose(seq_running) |-> seq_start)
        else $error("sequence began without start pulse");
    chk_oneshot_halt: assert property (
        meas.valid && seq_running && cfg.conversion_mode_select
        && $past(cfg.conversion_mode_select) |-> ##[1:2] !seq_running)
        else $error("one-shot sequencer did not halt");
endmodule

bind arc_regs arc_regs_monitor arc_regs_monitor_inst (.mclk(mclk), .reset(reset), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .convert_start(convert_start), .meas(meas),
    .seq_start(seq_start), .seq_running(seq_running), .cfg(cfg), .ecc_check(ecc_check));

// file: sim/arc_regs_tb.sv
`timescale 1ns/100ps
module arc_regs_tb;
    logic               mclk;
    logic               reset;
    logic               convert_start;
    arc_pkg::arc_meas_s meas;
    arc_pkg::arc_req_s  req;
    logic [15:0]        rd_data;
    logic               rd_valid;
    logic               seq_start;
    logic               seq_running;
    arc_pkg::arc_cfg_s  cfg;
    logic [4:0]         ecc_check;
    int                 n_errors = 0;
    int                 n_checks = 0;

    arc_regs arc_regs_inst (.mclk(mclk), .reset(reset), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .convert_start(convert_start), .meas(meas),
        .seq_start(seq_start), .seq_running(seq_running), .cfg(cfg), .ecc_check(ecc_check));
    arc_host_model arc_host_model_inst (.mclk(mclk), .rd_data(rd_data),
        .rd_valid(rd_valid), .req(req));

    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    // ==========================================
    // shared tasks
    task automatic final_report();
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] p, input logic [5:0] a, input logic [15:0] d);
        logic [15:0] q;
        bit          ok;
        arc_host_model_inst.access(1'b1, p, a, d, q, ok);
    endtask
    task automatic rd(input logic [1:0] p, input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] q;
        bit          ok;
        arc_host_model_inst.access(1'b0, p, a, 16'h0000, q, ok);
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED t=%0t read timed out", $time);
            final_report();
        end else begin
            expect_eq(q, exp);
        end
    endtask
    task automatic pulse_start();
        @(posedge mclk);
        #1 convert_start = 1;
        @(posedge mclk);
        #1 convert_start = 0;
    endtask
    task automatic deliver(input logic [13:0] s, c, input logic [14:0] m,
                           input logic [11:0] t);
        @(posedge mclk);
        #1 meas = '{1'b1, s, c, m, t};
        @(posedge mclk);
        #1 meas.valid = 0;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset_values();
        rd(arc_pkg::PAGE_CONFIG, arc_pkg::ADDR_GEN_CTRL, 16'h1230);
        expect_eq({3'h0, cfg}, 16'h0400);
        expect_eq({11'h000, ecc_check}, 16'h0004);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'h0000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_COSINE_RAW, 16'h0000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_VECTOR_MAG, 16'h0000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_DIE_TEMP, 16'h0000);
    endtask
    task automatic t_one_shot();
        real degc;
        wr(arc_pkg::PAGE_CONFIG, arc_pkg::ADDR_GEN_CTRL, 16'h1231);
        pulse_start();
        expect_eq({15'h0000, seq_running}, 16'h0001);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'h2000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_COSINE_RAW, 16'h2000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_DIE_TEMP, 16'hFFF0);
        deliver(14'h2ABC, 14'h1234, 15'h5A5A, 12'h79F);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'hAAF0);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_COSINE_RAW, 16'h48D0);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_VECTOR_MAG, 16'hB4B4);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_DIE_TEMP, 16'h79F0);
        degc = arc_host_model_inst.to_celsius(rd_data);
        n_checks++;
        if (degc < 49.99 || degc > 50.01) begin
            n_errors++;
            $display("CHECK FAILED t=%0t temperature conversion wrong", $time);
        end
        expect_eq({15'h0000, seq_running}, 16'h0000);
    endtask
    task automatic t_continuous();
        wr(arc_pkg::PAGE_CONFIG, arc_pkg::ADDR_GEN_CTRL, 16'h1230);
        pulse_start();
        deliver(14'h0001, 14'h3FFF, 15'h7FFF, 12'h000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_VECTOR_MAG, 16'hFFFF);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_VECTOR_MAG, 16'hFFFE);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'h0005);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_COSINE_RAW, 16'hFFFD);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'h0004);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_DIE_TEMP, 16'h0000);
    endtask
    task automatic t_writes();
        logic [15:0] v [2] = '{16'hFFFE, 16'h0230};
        logic [12:0] c [2] = '{13'h1EFF, 13'h0000};
        logic [4:0]  e [2] = '{5'h11, 5'h19};
        foreach (v[i]) begin
            wr(arc_pkg::PAGE_CONFIG, arc_pkg::ADDR_GEN_CTRL, v[i]);
            rd(arc_pkg::PAGE_CONFIG, arc_pkg::ADDR_GEN_CTRL, v[i]);
            expect_eq({3'h0, cfg}, {3'h0, c[i]});
            expect_eq({11'h000, ecc_check}, {11'h000, e[i]});
        end
        wr(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_DIE_TEMP, 16'h1234);
        wr(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'h5555);
        wr(arc_pkg::PAGE_CONFIG, 6'h11, 16'hFFFF);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_DIE_TEMP, 16'h0000);
        rd(arc_pkg::PAGE_RESULT, arc_pkg::ADDR_SINE_RAW, 16'h0004);
        rd(arc_pkg::PAGE_CONFIG, 6'h11, 16'h0000);
    endtask
    // ==========================================
    // main sequence
    initial begin
        reset = 1;
        convert_start = 0;
        meas = '0;
        repeat (12) @(posedge mclk);
        #1 reset = 0;
        t_reset_values();
        t_one_shot();
        t_continuous();
        t_writes();
        final_report();
    end
endmodule
